/* File: rtl/arith_compare_decoder.sv */
// Decoder and executor for the add, subtract and compare-and-skip group.
// Assumes instructions and memory loads come from logic on sys_clk; the
// data memory (256 digits) lives here so operands are read in one cycle.
`timescale 1ns/1ps
`default_nettype none

module arith_compare_decoder (
    input  wire logic                                   sys_clk,
    input  wire logic                                   rst,
    input  wire logic                                   instr_valid,
    input  wire arith_compare_pkg::instr_s              instr,
    input  wire logic [arith_compare_pkg::BANK_W-1:0]   bank_sel,
    input  wire arith_compare_pkg::mem_wr_s             load,
    output logic      [arith_compare_pkg::PC_W-1:0]     pc_ff,
    output logic                                        carry_ff,
    output logic                                        skip_pending_ff,
    output logic                                        done_ff,
    output arith_compare_pkg::mem_wr_s                  wb_ff
);

    // Digits live here so both operands are read in the cycle they are named
    logic [arith_compare_pkg::DIGIT_W-1:0]
        mem_ff [arith_compare_pkg::MEM_DEPTH];

    logic                                  exec;
    logic [3:0]                            grp;
    logic                                  is_arith;
    logic                                  is_sub;
    logic                                  is_imm;
    logic                                  is_cmp;
    logic                                  cmp_eq;
    logic [arith_compare_pkg::ADDR_W-1:0]  m_addr;
    logic [arith_compare_pkg::ADDR_W-1:0]  r_addr;
    logic [arith_compare_pkg::DIGIT_W-1:0] m_val;
    logic [arith_compare_pkg::DIGIT_W-1:0] r_val;
    logic [arith_compare_pkg::DIGIT_W-1:0] opnd_b;
    logic                                  cin;
    logic [arith_compare_pkg::DIGIT_W:0]   sum;
    logic                                  nxt_skip;
    arith_compare_pkg::mem_wr_s            nxt_wb;

    // Carry or borrow is the fifth bit of the widened result
    function automatic logic carry_out(input logic [4:0] v);
        carry_out = v[4];
    endfunction

    // Address build: bank, row, column, used for both operands
    function automatic logic [arith_compare_pkg::ADDR_W-1:0] mk_addr(
        input logic [arith_compare_pkg::BANK_W-1:0]  b,
        input logic [arith_compare_pkg::ROW_W-1:0]   r,
        input logic [arith_compare_pkg::COL_W-1:0]   c);
        mk_addr = {b, r, c};
    endfunction

    // Operand decode: a suppressed instruction only steps the PC and clears the pending skip
    assign exec     = instr_valid && !skip_pending_ff;
    assign grp      = instr.opcode[5:2];
    assign is_arith = (grp == arith_compare_pkg::GRP_PLUS_REG_MEM)  ||
                      (grp == arith_compare_pkg::GRP_PLUS_MEM_IMM)  ||
                      (grp == arith_compare_pkg::GRP_MINUS_REG_MEM) ||
                      (grp == arith_compare_pkg::GRP_MINUS_MEM_IMM);
    assign is_sub   = (grp == arith_compare_pkg::GRP_MINUS_REG_MEM) ||
                      (grp == arith_compare_pkg::GRP_MINUS_MEM_IMM);
    assign cmp_eq   = (instr.opcode == arith_compare_pkg::OP_SKIP_REG_EQUAL) ||
                      (instr.opcode == arith_compare_pkg::OP_SKIP_IMM_EQUAL);
    assign is_cmp   = cmp_eq ||
        (instr.opcode == arith_compare_pkg::OP_SKIP_REG_NOT_BELOW) ||
        (instr.opcode == arith_compare_pkg::OP_SKIP_IMM_NOT_BELOW);
    // Immediate forms: 0101, 0111, 001101, 001111 all have bit 12 set
    assign is_imm   = instr.opcode[2];

    // Operand fetch: M in the selected bank, r fixed in bank 0 row 0
    assign m_addr = mk_addr(bank_sel, instr.row_address_field,
                            instr.column_address_field);
    assign r_addr = mk_addr(arith_compare_pkg::REG_BANK,
                            arith_compare_pkg::REG_ROW,
                            instr.register_index_field);
    assign m_val  = mem_ff[m_addr];
    assign r_val  = mem_ff[r_addr];

    // Datapath: first operand is r or M, second is M or I
    always_comb begin
        logic [arith_compare_pkg::DIGIT_W-1:0] opnd_a;
        opnd_a = is_imm ? m_val : r_val;
        opnd_b = is_imm ? instr.register_index_field : m_val;
        cin    = is_arith && carry_ff &&
                 instr.opcode[arith_compare_pkg::CARRY_IN_BIT];
        if (is_sub || is_cmp) begin
            sum = {1'b0, opnd_a} - {1'b0, opnd_b} - {4'h0, cin};
        end else begin
            sum = {1'b0, opnd_a} + {1'b0, opnd_b} + {4'h0, cin};
        end
    end

    // Skip decision and write-back request
    always_comb begin
        nxt_skip = 1'b0;
        nxt_wb   = '0;
        if (exec && is_arith) begin
            nxt_skip     = carry_out(sum) &&
                           instr.opcode[arith_compare_pkg::SKIP_BIT];
            nxt_wb.valid = 1'b1;
            nxt_wb.addr  = is_imm ? m_addr : r_addr;
            nxt_wb.data  = sum[arith_compare_pkg::DIGIT_W-1:0];
        end else if (exec && is_cmp) begin
            // Compares never store: zero test or no-borrow test only
            nxt_skip = cmp_eq ? (sum[arith_compare_pkg::DIGIT_W-1:0] == 4'h0)
                              : !carry_out(sum);
        end
    end

    // Data memory: an executed write-back beats a load in the same cycle
    always_ff @(posedge sys_clk) begin
        if (nxt_wb.valid) begin
            mem_ff[nxt_wb.addr] <= nxt_wb.data;
        end else if (load.valid) begin
            mem_ff[load.addr] <= load.data;
        end
    end

    // Program counter: every instruction, executed or skipped, steps once
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pc_ff <= arith_compare_pkg::PC_RESET;
        end else if (instr_valid) begin
            pc_ff <= pc_ff + 12'h001;
        end
    end

    // Skip request lives until the next instruction consumes it
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            skip_pending_ff <= 1'b0;
        end else if (instr_valid) begin
            skip_pending_ff <= nxt_skip;
        end
    end

    // Carry/borrow flag, touched only by add and subtract
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            carry_ff <= arith_compare_pkg::CARRY_RESET;
        end else if (exec && is_arith) begin
            carry_ff <= carry_out(sum);
        end
    end

    // Report of each write and each accepted instruction
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wb_ff   <= '0;
            done_ff <= 1'b0;
        end else begin
            wb_ff   <= nxt_wb;
            done_ff <= instr_valid;
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence skip_taken_s;
        exec && is_arith && instr.opcode[0] && sum[4];
    endsequence
    sequence next_instr_s;
        instr_valid;
    endsequence

    skip_chain_a: assert property (skip_taken_s ##1 next_instr_s |=>
        !wb_ff.valid && !skip_pending_ff)
        else $error("Skipped instruction was executed");
    pc_step_a: assert property (instr_valid |=>
        pc_ff == $past(pc_ff) + 12'h001)
        else $error("Program counter did not advance by one");
    done_step_a: assert property (instr_valid |=> done_ff)
        else $error("Accepted instruction gave no done pulse");
    reg_bank_a: assert property (exec && is_arith && !is_imm |=>
        wb_ff.valid && wb_ff.addr[7:4] == 4'h0)
        else $error("Register result left bank 0 row 0");
    mem_bank_a: assert property (exec && is_arith && is_imm |=>
        wb_ff.addr == {$past(bank_sel), $past(instr.row_address_field),
                       $past(instr.column_address_field)})
        else $error("Memory result at wrong address");
    add_value_a: assert property (exec && grp == 4'h4 &&
        !instr.opcode[1] |=> wb_ff.data == 4'($past(r_val) + $past(m_val)))
        else $error("Register add result wrong");
    imm_add_a: assert property (exec && grp == 4'h5 &&
        !instr.opcode[1] |=> wb_ff.data ==
        4'($past(m_val) + $past(instr.register_index_field)))
        else $error("Immediate add result wrong");
    borrow_flag_a: assert property (exec && grp == 4'h6 &&
        !instr.opcode[1] |=> carry_ff == ($past(r_val) < $past(m_val)))
        else $error("Borrow flag wrong after subtract");
    cmp_nowrite_a: assert property (exec && is_cmp |=>
        !wb_ff.valid && $stable(carry_ff))
        else $error("Compare changed memory or flag");
    imm_ge_a: assert property (exec && instr.opcode == 6'h0f |=>
        skip_pending_ff ==
        ($past(m_val) >= $past(instr.register_index_field)))
        else $error("Immediate not-below skip wrong");
    // The instruction after a taken equal compare must leave no write
    eq_skip_a: assert property (exec && instr.opcode == 6'h01 &&
        r_val == m_val |=> skip_pending_ff ##1 !wb_ff.valid)
        else $error("Equal compare did not skip");
    sub_imm_a: assert property (exec && grp == 4'h7 &&
        instr.opcode[0] && !instr.opcode[1] &&
        m_val < instr.register_index_field |=> skip_pending_ff && carry_ff)
        else $error("Immediate subtract borrow skip missing");

endmodule

`default_nettype wire

/* File: shared/arith_compare_pkg.sv */
// Constants, field layouts and carriers for the arithmetic/compare decoder.
// Assumes one instruction-cycle clock shared by the whole core.
package arith_compare_pkg;

    // Widths
    localparam int WORD_W  = 16;
    localparam int PC_W    = 12;
    localparam int DIGIT_W = 4;
    localparam int BANK_W  = 2;
    localparam int ROW_W   = 2;
    localparam int COL_W   = 4;
    localparam int ADDR_W  = BANK_W + ROW_W + COL_W;
    localparam int MEM_DEPTH = 256;

    // Operation codes in bits 15..10 (full) and 15..12 (group)
    localparam logic [5:0] OP_SKIP_REG_EQUAL     = 6'h01;
    localparam logic [5:0] OP_SKIP_REG_NOT_BELOW = 6'h03;
    localparam logic [5:0] OP_SKIP_IMM_EQUAL     = 6'h0d;
    localparam logic [5:0] OP_SKIP_IMM_NOT_BELOW = 6'h0f;
    localparam logic [3:0] GRP_PLUS_REG_MEM      = 4'h4;
    localparam logic [3:0] GRP_PLUS_MEM_IMM      = 4'h5;
    localparam logic [3:0] GRP_MINUS_REG_MEM     = 4'h6;
    localparam logic [3:0] GRP_MINUS_MEM_IMM     = 4'h7;

    // Option bits inside the operation code
    localparam int CARRY_IN_BIT = 1;   // instruction bit 11
    localparam int SKIP_BIT     = 0;   // instruction bit 10

    // Reset values
    localparam logic [PC_W-1:0]    PC_RESET    = 12'h000;
    localparam logic               CARRY_RESET = 1'b0;
    localparam logic [ADDR_W-1:0]  ADDR_RESET  = 8'h00;
    localparam logic [DIGIT_W-1:0] DIGIT_RESET = 4'h0;
    localparam logic [BANK_W-1:0]  REG_BANK    = 2'h0;
    localparam logic [ROW_W-1:0]   REG_ROW     = 2'h0;

    // Instruction word split into its fields
    typedef struct packed {
        logic [5:0]         opcode;
        logic [ROW_W-1:0]   row_address_field;
        logic [COL_W-1:0]   column_address_field;
        logic [DIGIT_W-1:0] register_index_field;  // also immediate
    } instr_s;

    // Data-memory write request / write-back report
    typedef struct packed {
        logic               valid;
        logic [ADDR_W-1:0]  addr;
        logic [DIGIT_W-1:0] data;
    } mem_wr_s;

endpackage

/* File: bench/arith_compare_decoder_test.sv */
// Self-checking bench for the add, subtract and compare-and-skip decoder.
// Assumes the shared package is compiled first; the bench drives every port.
`timescale 1ns/1ps
`default_nettype none

module arith_compare_decoder_test;
    typedef struct packed {
        logic [11:0] pc;
        logic        cy;
        logic        sk;
        logic        wv;
        logic [7:0]  wa;
        logic [3:0]  wd;
    } exp_s;

    logic                       sys_clk;
    logic                       rst;
    logic                       instr_valid;
    arith_compare_pkg::instr_s  instr;
    logic [1:0]                 bank_sel;
    arith_compare_pkg::mem_wr_s load;
    logic [11:0]                pc_ff;
    logic                       carry_ff;
    logic                       skip_pending_ff;
    logic                       done_ff;
    arith_compare_pkg::mem_wr_s wb_ff;
    exp_s                       exp_q[$];
    exp_s                       mon_e;
    logic [3:0]                 mem[256];
    logic [15:0]                seed;
    logic [15:0]                w;
    logic [15:0]                wb_seen;
    logic [11:0]                pc_m;
    logic                       cy_m;
    logic                       sk_m;
    int                         err_count;
    int                         samples_checked;
    int                         cycles;

    arith_compare_decoder DUT (
        .sys_clk         (sys_clk),
        .rst             (rst),
        .instr_valid     (instr_valid),
        .instr           (instr),
        .bank_sel        (bank_sel),
        .load            (load),
        .pc_ff           (pc_ff),
        .carry_ff        (carry_ff),
        .skip_pending_ff (skip_pending_ff),
        .done_ff         (done_ff),
        .wb_ff           (wb_ff)
    );

    // 200 MHz clock
    always #2.5 sys_clk = ~sys_clk;

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] want);
        samples_checked++;
        if (seen !== want) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic results();
        if (err_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Hang guard: the whole run needs under nine hundred cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 4000) begin
            err_count++;
            results();
        end
    end

    // Present one word, then predict what the edge that takes it must do
    task automatic exec(input logic v, input logic [15:0] iw,
                        input logic [1:0] b);
        logic [7:0] ra;
        logic [7:0] ma;
        logic [5:0] op;
        logic [3:0] x;
        logic [3:0] y;
        logic [4:0] s;
        exp_s       e;
        ra = {4'h0, iw[3:0]};
        ma = {b, iw[9:4]};
        op = iw[15:10];
        instr_valid = v;
        instr = iw;
        bank_sel = b;
        @(posedge sys_clk);
        #1;
        if (!v) return;
        e = '0;
        e.cy = cy_m;
        pc_m++;
        e.pc = pc_m;
        // A pending skip leaves memory and flag alone
        if (!sk_m) begin
            x = op[2] ? mem[ma] : mem[ra];
            y = op[2] ? iw[3:0] : mem[ma];
            if (op[5:4] == 2'h1) begin
                // Five-bit sum: bit 4 is carry, or borrow when negative
                s = op[3] ? {1'b0, x} - {1'b0, y} - (op[1] & cy_m)
                          : {1'b0, x} + {1'b0, y} + (op[1] & cy_m);
                e.wv = 1'b1;
                e.wa = op[2] ? ma : ra;
                e.wd = s[3:0];
                e.cy = s[4];
                e.sk = op[0] & s[4];
                mem[e.wa] = s[3:0];
            end else if (op == 6'h01 || op == 6'h0d) begin
                e.sk = (x == y);
            end else if (op == 6'h03 || op == 6'h0f) begin
                e.sk = (x >= y);
            end
        end
        cy_m = e.cy;
        sk_m = e.sk;
        exp_q.push_back(e);
    endtask

    // Results settle by the falling edge; one note per done pulse
    always @(negedge sys_clk) begin
        if (done_ff === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("spurious done", 16'h1, 16'h0);
            end else begin
                mon_e = exp_q.pop_front();
                check("pc", {4'h0, pc_ff}, {4'h0, mon_e.pc});
                check("carry", {15'h0, carry_ff}, {15'h0, mon_e.cy});
                check("skip", {15'h0, skip_pending_ff},
                      {15'h0, mon_e.sk});
                // Address and data only mean something with valid
                wb_seen = mon_e.wv ? {3'h0, wb_ff} : {15'h0, wb_ff.valid};
                check("wb", wb_seen,
                      {3'h0, mon_e.wv, mon_e.wa, mon_e.wd});
            end
        end else begin
            // No write may appear without an accepted instruction
            check("idle wb", {15'h0, wb_ff.valid}, 16'h0);
        end
    end

    // Random words: half add/sub groups, a quarter compares, rest foreign
    task automatic run(input int n);
        logic [5:0] cmp_tab[4];
        cmp_tab = '{6'h01, 6'h03, 6'h0d, 6'h0f};
        repeat (n) begin
            seed = lfsr(seed);
            w = seed;
            if (!seed[15]) w[15:12] = {2'b01, seed[13:12]};
            else if (!seed[14]) w[15:10] = cmp_tab[seed[13:12]];
            seed = lfsr(seed);
            exec(seed[2:0] != 3'h0, w, seed[5:4]);
        end
    endtask

    initial begin
        sys_clk = 1'b0;
        rst = 1'b1;
        instr_valid = 1'b0;
        instr = '0;
        bank_sel = 2'h0;
        load = '0;
        seed = 16'h001d;
        pc_m = 12'h000;
        cy_m = 1'b0;
        sk_m = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        // Preload every digit of all four banks
        for (int i = 0; i < 256; i++) begin
            seed = lfsr(seed);
            load = {1'b1, 8'(i), seed[3:0]};
            mem[i] = seed[3:0];
            @(posedge sys_clk);
            #1;
        end
        load = '0;
        run(500);
        // Write-back beats a load aimed at the same digit, seen via compares
        load = {1'b1, 8'h03, 4'h2};
        mem[8'h03] = 4'h2;
        exec(1'b1, 16'hf000, 2'h0);     // Foreign word clears any skip
        load = {1'b1, 8'h03, 4'ha};
        exec(1'b1, 16'h5031, 2'h0);     // Digit 03 plus 1 wins
        load = '0;
        exec(1'b1, 16'h3433, 2'h0);     // Digit equals 3: skip
        exec(1'b1, 16'h5031, 2'h0);     // Dropped
        exec(1'b1, 16'h0433, 2'h0);     // r and M are one digit: skip
        exec(1'b1, 16'h5031, 2'h0);     // Dropped
        exec(1'b0, 16'h0000, 2'h0);
        exec(1'b0, 16'h0000, 2'h0);
        // Mid-run reset clears the state but keeps memory
        rst = 1'b1;
        #1;
        check("pc rst", {4'h0, pc_ff}, 16'h0);
        check("flags rst", {14'h0, carry_ff, skip_pending_ff},
              16'h0);
        @(posedge sys_clk);
        #1;
        rst = 1'b0;
        pc_m = 12'h000;
        cy_m = 1'b0;
        sk_m = 1'b0;
        run(100);
        exec(1'b0, 16'h0000, 2'h0);
        exec(1'b0, 16'h0000, 2'h0);
        // Every noted result must have met its done pulse by now
        check("left in queue", 16'(exp_q.size()), 16'h0);
        results();
    end
endmodule

`default_nettype wire
